// file: rtl/ptf_pkg.sv
package ptf_pkg;

    // ==========================================
    // register map (byte offsets)
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_T1SIZE = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_SIZE2 = 5'h0C;
    localparam logic [4:0] ADDR_SIZE3 = 5'h10;
    localparam logic [4:0] ADDR_REMAIN = 5'h14;

    // ==========================================
    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_NONSTD_BIT = 3;
    localparam int CTRL_COPY_BIT = 4;
    localparam int ST_PRESENT_LSB = 0;
    localparam int ST_POUT_LSB = 3;
    localparam int ST_BUSY_BIT = 6;
    localparam int ST_REFUSED_BIT = 7;
    localparam int ST_SHIFT_BIT = 8;
    localparam int ST_CONNECT_BIT = 9;
    localparam int SZ_ID_LSB = 5;
    localparam int SZ_UNKNOWN_BIT = 10;

    // ==========================================
    // reset values and widths
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [4:0] T1SIZE_RESET = 5'h00;
    localparam int NUM_TRAYS = 3;
    localparam int SIZE_W = 5;
    localparam int ROT_W = 8;
    localparam int SYNC_W = 23;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 23'h3F_F000;

    // ==========================================
    // size switch codes and decoded size ids
    localparam logic [4:0] CODE_297X420_SEF = 5'h19;
    localparam logic [4:0] CODE_210X297_SEF = 5'h09;
    localparam logic [4:0] CODE_210X297_LEF = 5'h18;
    localparam logic [4:0] CODE_257X394_SEF = 5'h13;
    localparam logic [4:0] CODE_182X257_SEF = 5'h15;
    localparam logic [4:0] CODE_267X390 = 5'h06;
    localparam logic [4:0] ID_UNKNOWN = 5'h00;
    localparam logic [4:0] ID_297X420_SEF = 5'h01;
    localparam logic [4:0] ID_210X297_SEF = 5'h02;
    localparam logic [4:0] ID_210X297_LEF = 5'h03;
    localparam logic [4:0] ID_257X394_SEF = 5'h04;
    localparam logic [4:0] ID_182X257_SEF = 5'h05;
    localparam logic [4:0] ID_267X390 = 5'h06;

    typedef enum logic [1:0] {FEED_IDLE, FEED_PICK, FEED_GRIP} ptf_feed_state_t;

    function automatic logic [4:0] ptf_size_decode(input logic [4:0] code);
        logic [4:0] id;
        id = ID_UNKNOWN;
        unique case (code)
            CODE_297X420_SEF: id = ID_297X420_SEF;
            CODE_210X297_SEF: id = ID_210X297_SEF;
            CODE_210X297_LEF: id = ID_210X297_LEF;
            CODE_257X394_SEF: id = ID_257X394_SEF;
            CODE_182X257_SEF: id = ID_182X257_SEF;
            CODE_267X390: id = ID_267X390;
            default: id = ID_UNKNOWN;
        endcase
        return id;
    endfunction : ptf_size_decode

endpackage : ptf_pkg

// file: rtl/ptf_tray_ctrl.sv
// Notes on behaviour
// - trays 2,3 insertion seen, lift motor on
// - tray 1 presence from connector signal
// - paper loaded: pick-up solenoid and lift on
// - lift sensor off stops lift motor
// - lift sensor on again restarts lift
// - unselected station separation solenoid off
// - start turns on feed, grip, separation, pick-up
// - leading edge: pick-up off, grip stays on
// - remaining paper from lift rotation, four levels
// - paper end sensor off flags paper out
// - trays 2,3 size is five-bit code
// - switch on (low level) reads as one
// - code 11001 is 297x420 short edge
// - code 01001 is 210x297 short edge
// - code 11000 is 210x297 long edge
// - code 10011 is 257x394 short edge
// - code 10101 is 182x257 short edge
// - code 00110 is 267x390
// - unknown size refused unless enabled
// - tandem tray size from stored setting
// - tandem feeds right, shifts left stack over
// - copying, left empty: connect solenoid on
module ptf_tray_ctrl (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // avalon-mm slave
    input wire logic [4:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    // tray sensors
    input wire logic TRAY1_SET_IN,
    input wire logic [4:0] SIZE2_SW_N_IN,
    input wire logic [4:0] SIZE3_SW_N_IN,
    input wire logic [2:0] PAPER_END_IN,
    input wire logic [2:0] LIFT_SNS_IN,
    input wire logic [2:0] FEED_SNS_IN,
    input wire logic LEFT_PAPER_IN,
    input wire logic [1:0] LIFT_ROT_IN,
    // tray actuators
    output logic [2:0] LIFT_MOTOR_OUT,
    output logic [2:0] PICK_SOL_OUT,
    output logic [2:0] SEP_SOL_OUT,
    output logic [2:0] FEED_MOTOR_OUT,
    output logic [2:0] GRIP_MOTOR_OUT,
    output logic TANDEM_SHIFT_OUT,
    output logic TANDEM_CONNECT_OUT
);

    // ==========================================
    // input synchronisers
    logic [ptf_pkg::SYNC_W-1:0] sync1_reg;
    logic [ptf_pkg::SYNC_W-1:0] sync2_reg;
    wire [ptf_pkg::SYNC_W-1:0] pins_raw = {TRAY1_SET_IN, SIZE2_SW_N_IN, SIZE3_SW_N_IN, PAPER_END_IN,
                                          LIFT_SNS_IN, FEED_SNS_IN, LEFT_PAPER_IN, LIFT_ROT_IN};

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            // idle pin levels: size switches read as off, no false insertion
            sync1_reg <= ptf_pkg::SYNC_RESET;
            sync2_reg <= ptf_pkg::SYNC_RESET;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    wire tray1_set_s = sync2_reg[22];
    wire [4:0] size2_n_s = sync2_reg[21:17];
    wire [4:0] size3_n_s = sync2_reg[16:12];
    wire [2:0] paper_s = sync2_reg[11:9];
    wire [2:0] lift_sns_s = sync2_reg[8:6];
    wire [2:0] feed_sns_s = sync2_reg[5:3];
    wire left_paper_s = sync2_reg[2];
    wire [1:0] rot_s = sync2_reg[1:0];

    // ==========================================
    // size codes and presence
    wire [4:0] code2 = ~size2_n_s;
    wire [4:0] code3 = ~size3_n_s;
    wire [4:0] id2 = ptf_pkg::ptf_size_decode(code2);
    wire [4:0] id3 = ptf_pkg::ptf_size_decode(code3);
    wire unk2 = (id2 == ptf_pkg::ID_UNKNOWN);
    wire unk3 = (id3 == ptf_pkg::ID_UNKNOWN);
    // any switch pressed means a cassette is in
    wire [2:0] present = {|code3, |code2, tray1_set_s};

    logic [2:0] present_prev_reg;
    logic [2:0] paper_prev_reg;
    logic [2:0] feed_prev_reg;
    logic [1:0] rot_prev_reg;

    wire [2:0] ins_pulse = present & ~present_prev_reg;
    wire [2:0] paper_rise = paper_s & ~paper_prev_reg;
    wire [2:0] paper_fall = ~paper_s & paper_prev_reg;
    wire [2:0] feed_rise = feed_sns_s & ~feed_prev_reg;
    wire [2:0] feed_fall = ~feed_sns_s & feed_prev_reg;
    wire [1:0] rot_step = rot_s & ~rot_prev_reg;

    // ==========================================
    // control registers
    logic [4:0] ctrl_reg;
    logic [4:0] t1size_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic refused_reg;
    logic shift_reg;
    logic connect_reg;
    logic [2:0] pout_reg;
    logic [ptf_pkg::ROT_W-1:0] rot_cnt_reg [2];

    wire bus_req = AVS_READ_IN | AVS_WRITE_IN;
    wire bus_first = bus_req & wait_reg;
    wire bus_take = bus_req & ~wait_reg;
    wire wr_take = bus_take & AVS_WRITE_IN;
    wire wr_ctrl = wr_take & (AVS_ADDRESS_IN == ptf_pkg::ADDR_CTRL);
    wire wr_t1size = wr_take & (AVS_ADDRESS_IN == ptf_pkg::ADDR_T1SIZE);
    wire start_wr = wr_ctrl & AVS_WRITEDATA_IN[ptf_pkg::CTRL_START_BIT];
    wire [1:0] sel_wr = AVS_WRITEDATA_IN[ptf_pkg::CTRL_SEL_LSB +: 2];
    wire nonstd_en = ctrl_reg[ptf_pkg::CTRL_NONSTD_BIT];
    wire copying = ctrl_reg[ptf_pkg::CTRL_COPY_BIT];
    wire wait_next = ~(bus_req & wait_reg);

    // ==========================================
    // feed sequencer
    ptf_pkg::ptf_feed_state_t state_reg;
    ptf_pkg::ptf_feed_state_t state_next;
    logic [1:0] feed_tray_reg;

    wire [1:0] sel_idx = sel_wr - 2'h1;
    wire size_ok = (sel_wr == 2'h2) ? (~unk2 | nonstd_en) :
                   (sel_wr == 2'h3) ? (~unk3 | nonstd_en) : 1'b1;
    wire tandem_ok = (sel_wr != 2'h1) | ~shift_reg;
    wire accept = start_wr & (state_reg == ptf_pkg::FEED_IDLE) & (sel_wr != 2'h0) &
                  present[sel_idx] & paper_s[sel_idx] & size_ok & tandem_ok;
    wire ft_present = present[feed_tray_reg];
    wire [1:0] feed_tray_next = accept ? sel_idx : feed_tray_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ptf_pkg::FEED_IDLE: begin
                if (accept) begin
                    state_next = ptf_pkg::FEED_PICK;
                end
            end
            ptf_pkg::FEED_PICK: begin
                if (!ft_present) begin
                    state_next = ptf_pkg::FEED_IDLE;
                end else if (feed_rise[feed_tray_reg]) begin
                    state_next = ptf_pkg::FEED_GRIP;
                end
            end
            ptf_pkg::FEED_GRIP: begin
                if (!ft_present || feed_fall[feed_tray_reg]) begin
                    state_next = ptf_pkg::FEED_IDLE;
                end
            end
            default: state_next = ptf_pkg::FEED_IDLE;
        endcase
    end

    // ==========================================
    // lift motor and actuators per tray
    logic [2:0] lift_next;
    logic [2:0] pick_next;
    logic [2:0] sep_next;
    logic [2:0] fmot_next;
    logic [2:0] grip_next;

    generate
        for (genvar i = 0; i < ptf_pkg::NUM_TRAYS; i++) begin : g_tray
            wire is_ft = (feed_tray_next == 2'(i));
            wire busy_n = (state_next != ptf_pkg::FEED_IDLE) & is_ft;
            wire lift_start = ins_pulse[i] | paper_rise[i] | lift_sns_s[i];
            // keep running while the sensor stays active, stop when it clears
            assign lift_next[i] = present[i] & (LIFT_MOTOR_OUT[i] ? lift_sns_s[i] : lift_start);
            assign pick_next[i] = present[i] & ((busy_n & (state_next == ptf_pkg::FEED_PICK)) |
                                  (lift_next[i] & ~(busy_n & (state_next == ptf_pkg::FEED_GRIP))));
            assign sep_next[i] = present[i] & busy_n;
            assign fmot_next[i] = present[i] & busy_n & (state_next == ptf_pkg::FEED_PICK);
            assign grip_next[i] = present[i] & busy_n;
        end
    endgenerate

    // ==========================================
    // tandem tray and status
    wire shift_next = present[0] & left_paper_s & ~paper_s[0] &
                      ~((state_reg != ptf_pkg::FEED_IDLE) & (feed_tray_reg == 2'h0));
    wire connect_next = present[0] & copying & ~left_paper_s;
    // withdrawal beats set: a fall while the tray is absent does not flag
    wire [2:0] pout_next = present & (paper_fall | (pout_reg & ~paper_s));
    wire refused_next = start_wr ? ~accept : refused_reg;

    wire [1:0] level2 = rot_cnt_reg[0][ptf_pkg::ROT_W-1 -: 2];
    wire [1:0] level3 = rot_cnt_reg[1][ptf_pkg::ROT_W-1 -: 2];
    wire [31:0] status_word = {22'h00_0000, connect_reg, shift_reg, refused_reg,
                               (state_reg != ptf_pkg::FEED_IDLE), pout_reg, present};
    wire [31:0] rdata_next =
        (AVS_ADDRESS_IN == ptf_pkg::ADDR_CTRL) ? {27'h000_0000, ctrl_reg} :
        (AVS_ADDRESS_IN == ptf_pkg::ADDR_T1SIZE) ? {27'h000_0000, t1size_reg} :
        (AVS_ADDRESS_IN == ptf_pkg::ADDR_STATUS) ? status_word :
        (AVS_ADDRESS_IN == ptf_pkg::ADDR_SIZE2) ? {21'h00_0000, unk2, id2, code2} :
        (AVS_ADDRESS_IN == ptf_pkg::ADDR_SIZE3) ? {21'h00_0000, unk3, id3, code3} :
        (AVS_ADDRESS_IN == ptf_pkg::ADDR_REMAIN) ? {28'h000_0000, level3, level2} : 32'h0000_0000;

    // ==========================================
    // state registers
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            present_prev_reg <= '0;
            paper_prev_reg <= '0;
            feed_prev_reg <= '0;
            rot_prev_reg <= '0;
        end else begin
            present_prev_reg <= present;
            paper_prev_reg <= paper_s;
            feed_prev_reg <= feed_sns_s;
            rot_prev_reg <= rot_s;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= ptf_pkg::CTRL_RESET;
            t1size_reg <= ptf_pkg::T1SIZE_RESET;
        end else begin
            wait_reg <= wait_next;
            if (bus_first) begin
                rdata_reg <= rdata_next;
            end
            if (wr_ctrl) begin
                ctrl_reg <= {AVS_WRITEDATA_IN[4:1], 1'b0};
            end
            if (wr_t1size) begin
                t1size_reg <= AVS_WRITEDATA_IN[4:0];
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= ptf_pkg::FEED_IDLE;
            feed_tray_reg <= 2'h0;
            refused_reg <= 1'b0;
            shift_reg <= 1'b0;
            connect_reg <= 1'b0;
            pout_reg <= '0;
        end else begin
            state_reg <= state_next;
            feed_tray_reg <= feed_tray_next;
            refused_reg <= refused_next;
            shift_reg <= shift_next;
            connect_reg <= connect_next;
            pout_reg <= pout_next;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            LIFT_MOTOR_OUT <= '0;
            PICK_SOL_OUT <= '0;
            SEP_SOL_OUT <= '0;
            FEED_MOTOR_OUT <= '0;
            GRIP_MOTOR_OUT <= '0;
        end else begin
            LIFT_MOTOR_OUT <= lift_next;
            PICK_SOL_OUT <= pick_next;
            SEP_SOL_OUT <= sep_next;
            FEED_MOTOR_OUT <= fmot_next;
            GRIP_MOTOR_OUT <= grip_next;
        end
    end

    // rotation counters, cleared on withdrawal
    generate
        for (genvar j = 0; j < 2; j++) begin : g_rot
            always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    rot_cnt_reg[j] <= '0;
                end else if (!present[j+1]) begin
                    rot_cnt_reg[j] <= '0;
                end else if (rot_step[j] && LIFT_MOTOR_OUT[j+1] && !(&rot_cnt_reg[j])) begin
                    rot_cnt_reg[j] <= rot_cnt_reg[j] + 8'h01;
                end
            end
        end
    endgenerate

    assign AVS_WAITREQUEST_OUT = wait_reg;
    assign AVS_READDATA_OUT = rdata_reg;
    assign TANDEM_SHIFT_OUT = shift_reg;
    assign TANDEM_CONNECT_OUT = connect_reg;

    // ==========================================
    // assertions
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    insert_lift_a: assert property (ins_pulse[1] |=> LIFT_MOTOR_OUT[1])
        else $error("tray 2 insertion did not start lift");
    tray1_pres_a: assert property (!tray1_set_s |=> !LIFT_MOTOR_OUT[0] && !SEP_SOL_OUT[0])
        else $error("tray 1 driven while connector reports absent");
    paper_lift_a: assert property (paper_rise[2] && present[2] && state_reg == ptf_pkg::FEED_IDLE && !accept
        |=> LIFT_MOTOR_OUT[2] && PICK_SOL_OUT[2])
        else $error("paper load did not start lift and pick-up");
    lift_stop_a: assert property (LIFT_MOTOR_OUT[1] && !lift_sns_s[1] |=> !LIFT_MOTOR_OUT[1])
        else $error("lift kept running after sensor cleared");
    relift_a: assert property (present[2] && lift_sns_s[2] && !LIFT_MOTOR_OUT[2] |=> LIFT_MOTOR_OUT[2])
        else $error("lift not restarted on sensor");
    sep_sel_a: assert property ((state_reg == ptf_pkg::FEED_IDLE || feed_tray_reg != 2'h1)
        |-> !SEP_SOL_OUT[1])
        else $error("separation solenoid on for unselected station");
    start_on_a: assert property (accept && sel_wr == 2'h2 && present[1]
        |=> FEED_MOTOR_OUT[1] && GRIP_MOTOR_OUT[1] && SEP_SOL_OUT[1] && PICK_SOL_OUT[1])
        else $error("start did not energise station");
    edge_pick_a: assert property (state_reg == ptf_pkg::FEED_PICK && feed_tray_reg == 2'h1 && present[1] &&
        feed_rise[1] |=> !PICK_SOL_OUT[1] && GRIP_MOTOR_OUT[1] && state_reg == ptf_pkg::FEED_GRIP)
        else $error("leading edge did not release pick-up");
    pout_a: assert property (paper_fall[1] && present[1] |=> pout_reg[1] [*2])
        else $error("paper out not flagged");
    nonstd_a: assert property (start_wr && sel_wr == 2'h3 && unk3 && !nonstd_en
        |=> refused_reg && state_reg == ptf_pkg::FEED_IDLE)
        else $error("unknown size accepted while disabled");
    connect_a: assert property (present[0] && copying && !left_paper_s |=> TANDEM_CONNECT_OUT)
        else $error("connect solenoid not energised");
    withdraw_a: assert property ($fell(present[2]) |-> ##1 !LIFT_MOTOR_OUT[2] && !PICK_SOL_OUT[2] &&
        !SEP_SOL_OUT[2] && !GRIP_MOTOR_OUT[2])
        else $error("withdrawn tray still driven");
    bus_ack_a: assert property (bus_req && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("waitrequest did not pulse low once");

    shift_a: assert property (present[0] && left_paper_s && !paper_s[0] && state_reg == ptf_pkg::FEED_IDLE
        |=> TANDEM_SHIFT_OUT)
        else $error("tandem shift not requested");
    shift_block_a: assert property (start_wr && sel_wr == 2'h1 && shift_reg && state_reg == ptf_pkg::FEED_IDLE
        |=> refused_reg && state_reg == ptf_pkg::FEED_IDLE)
        else $error("tray 1 feed taken while shifting");
    size_sef_a: assert property (size2_n_s == 5'h16 |-> id2 == ptf_pkg::ID_210X297_SEF)
        else $error("switch levels decoded wrongly");
    size_large_a: assert property (size2_n_s == 5'h06 |-> id2 == ptf_pkg::ID_297X420_SEF)
        else $error("large size decoded wrongly");
    size_unknown_a: assert property (size2_n_s == 5'h00 |-> unk2)
        else $error("unlisted code not unknown");
    remain_clr_a: assert property (!present[1] |=> rot_cnt_reg[0] == '0)
        else $error("rotation count kept without tray");
    feed_off_a: assert property (state_reg == ptf_pkg::FEED_GRIP |-> !FEED_MOTOR_OUT[feed_tray_reg])
        else $error("feed motor on during grip");
    absent_refuse_a: assert property (start_wr && sel_wr == 2'h3 && !present[2] |=> refused_reg)
        else $error("start taken for absent tray");
    pout_clr_a: assert property (present[1] && paper_s[1] |=> !pout_reg[1])
        else $error("paper out kept with paper");
    connect_off_a: assert property (!copying |=> !TANDEM_CONNECT_OUT)
        else $error("connect on while not copying");
    tandem_size_a: assert property (wr_t1size |=> t1size_reg == $past(AVS_WRITEDATA_IN[4:0]))
        else $error("tandem size not stored");

    feed_done_c: cover property (state_reg == ptf_pkg::FEED_GRIP ##[1:1000] state_reg == ptf_pkg::FEED_IDLE);
    relift_c: cover property (!LIFT_MOTOR_OUT[1] ##1 LIFT_MOTOR_OUT[1] ##[1:100] !LIFT_MOTOR_OUT[1]);
    shift_c: cover property ($rose(TANDEM_SHIFT_OUT));
    refuse_c: cover property ($rose(refused_reg));
    insert_c: cover property ($rose(present[1]));

endmodule : ptf_tray_ctrl

// file: sim/paper_tray_feed_control_tb.sv
module paper_tray_feed_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // stimulus and observation
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] av_addr = 5'h00;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0000_0000;
    logic [31:0] av_rdata, rd;
    logic av_wait, shift, connect, tray1_set = 1'b0, left_paper = 1'b0;
    logic [4:0] sw2_n = 5'h1F, sw3_n = 5'h1F;
    logic [2:0] paper = 3'h0;
    logic [2:0] lift_sns, feed_sns, lift_mot, pick, sep, feed_mot, grip;
    logic [1:0] rot;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    ptf_tray_ctrl u_dut (
        .REF_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(av_addr), .AVS_READ_IN(av_rd),
        .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wdata), .AVS_READDATA_OUT(av_rdata),
        .AVS_WAITREQUEST_OUT(av_wait), .TRAY1_SET_IN(tray1_set), .SIZE2_SW_N_IN(sw2_n),
        .SIZE3_SW_N_IN(sw3_n), .PAPER_END_IN(paper), .LIFT_SNS_IN(lift_sns), .FEED_SNS_IN(feed_sns),
        .LEFT_PAPER_IN(left_paper), .LIFT_ROT_IN(rot), .LIFT_MOTOR_OUT(lift_mot), .PICK_SOL_OUT(pick),
        .SEP_SOL_OUT(sep), .FEED_MOTOR_OUT(feed_mot), .GRIP_MOTOR_OUT(grip),
        .TANDEM_SHIFT_OUT(shift), .TANDEM_CONNECT_OUT(connect)
    );

    ptf_tray_model u_model (
        .clk_in(clk), .rst_in(rst), .lift_in(lift_mot), .feed_in(feed_mot), .grip_in(grip),
        .lift_sns_out(lift_sns), .feed_sns_out(feed_sns), .rot_out(rot)
    );

    // ==========================================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        av_rd <= ~wr;
        av_wr <= wr;
        av_addr <= a;
        av_wdata <= d;
        do @(posedge clk); while (av_wait !== 1'b0);
        rd = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : bus

    // two sync stages plus one registered stage
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ==========================================
    // scenarios
    task automatic t_lift();
        @(posedge clk);
        sw2_n <= ~5'b01001;
        paper <= 3'b010;
        settle();
        check("lift2", lift_mot[1], 1'b1);
        check("pick2", pick[1], 1'b1);
        for (int k = 0; k < 400 && lift_sns[1] !== 1'b0; k++) @(posedge clk);
        settle();
        check("lift2 off", lift_mot[1], 1'b0);
        bus(0, ptf_pkg::ADDR_REMAIN, 0);
        check("remain2", rd[1:0], 2'h1);
    endtask : t_lift

    task automatic t_size();
        logic [4:0] code [7] = '{5'b11001, 5'b01001, 5'b11000, 5'b10011, 5'b10101, 5'b00110, 5'b11111};
        logic [4:0] id [7] = '{ptf_pkg::ID_297X420_SEF, ptf_pkg::ID_210X297_SEF, ptf_pkg::ID_210X297_LEF,
            ptf_pkg::ID_257X394_SEF, ptf_pkg::ID_182X257_SEF, ptf_pkg::ID_267X390, ptf_pkg::ID_UNKNOWN};
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            sw2_n <= ~code[i];
            settle();
            bus(0, ptf_pkg::ADDR_SIZE2, 0);
            check("size2", rd, {21'h0, id[i] == ptf_pkg::ID_UNKNOWN, id[i], code[i]});
        end
        @(posedge clk);
        sw2_n <= ~5'b01001;
        settle();
        bus(0, ptf_pkg::ADDR_STATUS, 0);
        check("present", rd[2:0], 3'b010);
    endtask : t_size

    task automatic t_feed();
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_0005);
        @(posedge clk);
        #1;
        check("feed2 on", {feed_mot[1], grip[1], sep[1], pick[1]}, 4'hF);
        check("sep only", sep, 3'b010);
        for (int k = 0; k < 40 && pick[1] !== 1'b0; k++) @(posedge clk);
        #1;
        check("grip carry", {feed_mot[1], grip[1], sep[1]}, 3'b011);
        for (int k = 0; k < 40 && lift_mot[1] !== 1'b1; k++) @(posedge clk);
        #1;
        check("relift", lift_mot[1], 1'b1);
        for (int k = 0; k < 40 && lift_sns[1] !== 1'b0; k++) @(posedge clk);
        settle();
        check("relift off", lift_mot[1], 1'b0);
        for (int k = 0; k < 40 && grip[1] !== 1'b0; k++) @(posedge clk);
        #1;
        check("feed done", {feed_mot, grip, pick}, 9'h000);
        @(posedge clk);
        paper <= 3'b000;
        settle();
        bus(0, ptf_pkg::ADDR_STATUS, 0);
        check("pout2", rd[5:3], 3'b010);
        @(posedge clk);
        paper <= 3'b010;
        settle();
        bus(0, ptf_pkg::ADDR_STATUS, 0);
        check("pout clr", rd[5:3], 3'b000);
    endtask : t_feed

    task automatic t_refuse();
        @(posedge clk);
        sw3_n <= 5'b00000;
        paper <= 3'b110;
        settle();
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_0007);
        bus(0, ptf_pkg::ADDR_STATUS, 0);
        check("refused3", {rd[7], feed_mot[2]}, 2'b10);
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_000E);
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_000F);
        @(posedge clk);
        #1;
        check("nonstd feed3", feed_mot[2], 1'b1);
        @(posedge clk);
        sw3_n <= 5'h1F;
        settle();
        check("withdrawn", {lift_mot[2], pick[2], sep[2], feed_mot[2], grip[2]}, 5'h00);
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_000F);
        bus(0, ptf_pkg::ADDR_STATUS, 0);
        check("absent refused", {rd[7], rd[2]}, 2'b10);
    endtask : t_refuse

    task automatic t_tandem();
        bus(0, ptf_pkg::ADDR_T1SIZE, 0);
        check("t1size rst", rd[4:0], ptf_pkg::T1SIZE_RESET);
        bus(1, ptf_pkg::ADDR_T1SIZE, 32'h0000_0015);
        bus(0, ptf_pkg::ADDR_T1SIZE, 0);
        check("t1size", rd, 32'h0000_0015);
        bus(1, 5'h1C, 32'h0000_FFFF);
        bus(0, 5'h1C, 0);
        check("unmapped", rd, 32'h0000_0000);
        @(posedge clk);
        tray1_set <= 1'b1;
        left_paper <= 1'b1;
        settle();
        check("shift", shift, 1'b1);
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_0003);
        bus(0, ptf_pkg::ADDR_STATUS, 0);
        check("tray1 st", {rd[8], rd[7], rd[0]}, 3'b111);
        @(posedge clk);
        paper <= 3'b011;
        left_paper <= 1'b0;
        settle();
        check("shift end", shift, 1'b0);
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_0010);
        settle();
        check("connect", connect, 1'b1);
        bus(1, ptf_pkg::ADDR_CTRL, 32'h0000_0000);
        settle();
        check("disconnect", connect, 1'b0);
    endtask : t_tandem

    initial begin
        repeat (16) @(posedge clk);
        #1;
        check("reset out", {av_wait, lift_mot, pick, sep, feed_mot, grip, shift, connect}, 18'h2_0000);
        @(posedge clk);
        rst <= 1'b0;
        t_lift();
        t_size();
        t_feed();
        t_refuse();
        t_tandem();
        print_verdict();
    end
endmodule : paper_tray_feed_control_tb

// file: sim/ptf_tray_model.sv
module ptf_tray_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // actuators from the controller
    input wire logic [2:0] lift_in,
    input wire logic [2:0] feed_in,
    input wire logic [2:0] grip_in,
    // sensors back to the controller
    output logic [2:0] lift_sns_out,
    output logic [2:0] feed_sns_out,
    output logic [1:0] rot_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // stack height and sheet travel per tray
    logic [7:0] height_reg [3];
    logic [4:0] travel_reg [3];
    logic [1:0] rot_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            height_reg <= '{3{8'h00}};
            travel_reg <= '{3{5'h00}};
            rot_reg <= 2'h0;
        end else begin
            rot_reg <= lift_in[2:1] & ~rot_reg;
            for (int i = 0; i < 3; i++) begin
                travel_reg[i] <= (feed_in[i] | grip_in[i]) ? travel_reg[i] + 5'h01 : 5'h00;
                // a sheet leaving lowers the stack top below feed height
                if (travel_reg[i] == 5'h06 && feed_in[i]) begin
                    height_reg[i] <= height_reg[i] - 8'h08;
                end else if (lift_in[i] && height_reg[i] < 8'hF0) begin
                    height_reg[i] <= height_reg[i] + 8'h01;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            lift_sns_out[i] = height_reg[i] < 8'hA0;
            feed_sns_out[i] = travel_reg[i] >= 5'h06 && travel_reg[i] < 5'h0E;
        end
    end
    assign rot_out = rot_reg;
endmodule : ptf_tray_model
